// *** hdl/iop_port_clock_block.sv ***
// One I/O port with its clock blocks, shared-pin override and timed transfers
`timescale 1ns/1ps
`default_nettype none
module iop_port_clock_block #(
	parameter int WIDTH = 4,
	parameter int SHIFT = 2
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_nrst,
	// Pins of this port
	input  wire logic [WIDTH-1:0]        i_pin,
	output logic      [WIDTH-1:0]        o_pin,
	output logic      [WIDTH-1:0]        o_pin_oe,
	// Pin override from links and narrower ports
	input  wire logic                    i_link_en,
	input  wire logic [WIDTH-1:0]        i_narrow_own,
	// Configuration
	input  wire logic                    i_port_en,
	input  wire logic                    i_dir_out,
	input  wire logic                    i_open_coll,
	input  wire logic                    i_buffered,
	input  wire logic                    i_strobe_en,
	input  wire logic [2:0]              i_clk_blk_sel,
	input  wire logic                    i_clk_blk_wr,
	input  wire logic [4:0]              i_blk_src_pin,
	input  wire logic [7:0]              i_blk_div,
	input  wire logic                    i_ext_clk_pin,
	// Core access, one cycle per request
	input  wire logic                    i_req,
	input  wire logic                    i_req_timed,
	input  wire logic                    i_req_cond,
	input  wire logic [15:0]             i_req_time,
	input  wire logic [WIDTH*SHIFT-1:0]  i_req_data,
	input  wire logic [WIDTH-1:0]        i_cond_val,
	input  wire logic                    i_strobe_in,
	output logic                         o_ack,
	output logic                         o_done,
	output logic [WIDTH*SHIFT-1:0]       o_rd_data,
	output logic [15:0]                  o_counter,
	output logic [15:0]                  o_timestamp,
	output logic                         o_output_strobe,
	output logic [2:0]                   o_clk_blk
);
	//==========================================================================
	// Reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) rst_sync_q <= 2'b00;
		else         rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	//==========================================================================
	// Pin synchronisers: change accepted once stages two and three agree
	logic [WIDTH-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_val_q, pin_val_d;
	logic [2:0]       ext_s_q;
	logic [2:0]       stb_s_q;
	logic             ext_val_q, ext_val_d, stb_val_q, stb_val_d;
	always_comb begin
		pin_val_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_val_q;
		ext_val_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_val_q;
		stb_val_d = (stb_s_q[1] == stb_s_q[2]) ? stb_s_q[2] : stb_val_q;
	end
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q  <= '0;
			pin_s2_q  <= '0;
			pin_s3_q  <= '0;
			pin_val_q <= '0;
			ext_s_q   <= 3'h0;
			stb_s_q   <= 3'h0;
			ext_val_q <= 1'b0;
			stb_val_q <= 1'b0;
		end else begin
			pin_s1_q  <= i_pin;
			pin_s2_q  <= pin_s1_q;
			pin_s3_q  <= pin_s2_q;
			pin_val_q <= pin_val_d;
			ext_s_q   <= {ext_s_q[1:0], i_ext_clk_pin};
			stb_s_q   <= {stb_s_q[1:0], i_strobe_in};
			ext_val_q <= ext_val_d;
			stb_val_q <= stb_val_d;
		end
	end

	//==========================================================================
	// Clock blocks: enable pulses, block 0 fixed to the reference rate
	logic [iop_pkg::NUM_CLK_BLK-1:0] blk_tick;
	logic [7:0] ref_cnt_q, ref_cnt_d;
	logic       ref_tick;
	logic       ext_prev_q;
	logic       ext_rise;
	logic [iop_pkg::NUM_CLK_BLK-1:0] blk_src_q, blk_src_d;
	logic [7:0] blk_div_q [iop_pkg::NUM_CLK_BLK];
	logic [7:0] blk_div_d [iop_pkg::NUM_CLK_BLK];
	logic [7:0] blk_cnt_q [iop_pkg::NUM_CLK_BLK];
	logic [7:0] blk_cnt_d [iop_pkg::NUM_CLK_BLK];
	logic [2:0] clk_blk_q, clk_blk_d;

	assign ref_tick = (ref_cnt_q == iop_pkg::REF_DIV_CYC - 8'h01);
	assign ext_rise = ext_val_q & ~ext_prev_q;

	always_comb begin
		ref_cnt_d = ref_tick ? 8'h00 : ref_cnt_q + 8'h01;
		clk_blk_d = clk_blk_q;
		blk_src_d = blk_src_q;
		for (int b = 0; b < iop_pkg::NUM_CLK_BLK; b++) begin
			blk_div_d[b] = blk_div_q[b];
			blk_cnt_d[b] = blk_cnt_q[b];
			blk_tick[b]  = 1'b0;
		end
		blk_tick[0] = ref_tick;
		// Blocks 1..5: reference or external 1-bit port clock, with divider
		for (int b = 1; b < iop_pkg::NUM_CLK_BLK; b++) begin
			if ((blk_src_q[b] ? ext_rise : ref_tick)) begin
				if (blk_cnt_q[b] >= blk_div_q[b]) begin
					blk_cnt_d[b] = 8'h00;
					blk_tick[b]  = 1'b1;
				end else begin
					blk_cnt_d[b] = blk_cnt_q[b] + 8'h01;
				end
			end
		end
		// Attach port and program the chosen block in one write
		if (i_clk_blk_wr && (i_clk_blk_sel < 3'(iop_pkg::NUM_CLK_BLK))) begin
			clk_blk_d = i_clk_blk_sel;
			if (i_clk_blk_sel != 3'h0) begin
				blk_src_d[i_clk_blk_sel] = i_blk_src_pin[i_clk_blk_sel-3'h1];
				blk_div_d[i_clk_blk_sel] = i_blk_div;
				blk_cnt_d[i_clk_blk_sel] = 8'h00;
			end
		end
	end
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_q  <= 8'h00;
			ext_prev_q <= 1'b0;
			clk_blk_q  <= iop_pkg::CLK_BLK_RST;
			blk_src_q  <= '0;
			for (int b = 0; b < iop_pkg::NUM_CLK_BLK; b++) begin
				blk_div_q[b] <= iop_pkg::DIV_RST;
				blk_cnt_q[b] <= 8'h00;
			end
		end else begin
			ref_cnt_q  <= ref_cnt_d;
			ext_prev_q <= ext_val_q;
			clk_blk_q  <= clk_blk_d;
			blk_src_q  <= blk_src_d;
			for (int b = 0; b < iop_pkg::NUM_CLK_BLK; b++) begin
				blk_div_q[b] <= blk_div_d[b];
				blk_cnt_q[b] <= blk_cnt_d[b];
			end
		end
	end

	//==========================================================================
	// Port sequencer: counter, SERDES, transfer register, timestamp
	logic                   tick;
	logic [WIDTH-1:0]       own;
	logic                   active;
	iop_pkg::iop_state_t    st_q, st_d;
	logic [15:0]            cnt_q, cnt_d, ts_q, ts_d, tgt_q, tgt_d;
	logic [WIDTH*SHIFT-1:0] xfer_q, xfer_d, shr_q, shr_d;
	logic [7:0]             slot_q, slot_d;
	logic [WIDTH-1:0]       out_q, out_d, cond_q, cond_d;
	logic                   ack_d, done_d, stb_d, ack_q, done_q, stb_q;
	logic                   cond_on_q, cond_on_d;
	logic                   go;
	logic [WIDTH-1:0]       smp;

	assign tick   = blk_tick[clk_blk_q];
	// Pins kept by this port: not taken by link nor by a narrower port
	assign own    = (i_link_en || !i_port_en) ? '0 : ~i_narrow_own;
	assign active = i_port_en && !i_link_en;
	assign smp    = pin_val_q & own;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		ts_d   = ts_q;
		tgt_d  = tgt_q;
		xfer_d = xfer_q;
		shr_d  = shr_q;
		slot_d = slot_q;
		out_d  = out_q;
		cond_d = cond_q;
		cond_on_d = cond_on_q;
		ack_d  = 1'b0;
		done_d = 1'b0;
		stb_d  = 1'b0;
		go     = 1'b0;
		if (tick) cnt_d = cnt_q + 16'h0001;
		// Request taken in one cycle; data parked in transfer register
		if (i_req && active && st_q == iop_pkg::IOP_IDLE) begin
			ack_d  = 1'b1;
			xfer_d = i_req_data;
			tgt_d  = i_req_time;
			cond_d = i_cond_val;
			cond_on_d = i_req_cond;  // Held so a later change of the input cannot end the wait
			slot_d = 8'h00;
			if (i_req_timed)                    st_d = iop_pkg::IOP_WAIT_TIME;
			else if (i_req_cond && !i_dir_out)  st_d = iop_pkg::IOP_WAIT_COND;
			else if (i_strobe_en && !i_dir_out) st_d = iop_pkg::IOP_WAIT_STB;
			else                                st_d = iop_pkg::IOP_WAIT_COND;
		end
		case (st_q)
			iop_pkg::IOP_IDLE: ;
			iop_pkg::IOP_WAIT_TIME: begin
				if (tick && cnt_q == tgt_q) go = 1'b1;
			end
			iop_pkg::IOP_WAIT_STB: begin
				if (tick && stb_val_q) go = 1'b1;
			end
			iop_pkg::IOP_WAIT_COND: begin
				if (tick && (i_dir_out || !cond_on_q || smp == (cond_q & own))) go = 1'b1;
			end
			default: st_d = iop_pkg::IOP_IDLE;
		endcase
		if (!active && st_q != iop_pkg::IOP_IDLE) st_d = iop_pkg::IOP_IDLE;
		// One slice per port edge; buffered mode shifts SHIFT slices
		if (go && active) begin
			if (i_dir_out) begin
				out_d = i_buffered ? xfer_q[slot_q*WIDTH +: WIDTH] : xfer_q[WIDTH-1:0];
				stb_d = i_strobe_en;
			end else begin
				shr_d = {smp, shr_q[WIDTH*SHIFT-1:WIDTH]};
			end
			if (!i_buffered || slot_q == 8'(SHIFT-1)) begin
				ts_d   = cnt_q;
				done_d = 1'b1;
				st_d   = iop_pkg::IOP_IDLE;
				if (!i_dir_out) xfer_d = i_buffered ? shr_d : {{(WIDTH*SHIFT-WIDTH){1'b0}}, smp};
			end else begin
				slot_d = slot_q + 8'h01;
				// Later slices of a timed transfer follow on the next port edges,
				// otherwise they would wait a whole counter wrap
				if (st_q == iop_pkg::IOP_WAIT_TIME) begin
					st_d      = iop_pkg::IOP_WAIT_COND;
					cond_on_d = 1'b0;
				end
			end
		end
	end
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= iop_pkg::IOP_IDLE;
			cnt_q  <= iop_pkg::CNT_RST;
			ts_q   <= iop_pkg::CNT_RST;
			tgt_q  <= iop_pkg::CNT_RST;
			xfer_q <= '0;
			shr_q  <= '0;
			slot_q <= 8'h00;
			out_q  <= '0;
			cond_q <= '0;
			cond_on_q <= 1'b0;
			ack_q  <= 1'b0;
			done_q <= 1'b0;
			stb_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			ts_q   <= ts_d;
			tgt_q  <= tgt_d;
			xfer_q <= xfer_d;
			shr_q  <= shr_d;
			slot_q <= slot_d;
			out_q  <= out_d;
			cond_q <= cond_d;
			cond_on_q <= cond_on_d;
			ack_q  <= ack_d;
			done_q <= done_d;
			stb_q  <= stb_d;
		end
	end

	//==========================================================================
	// Pin drivers registered; one direction for the whole port
	logic [WIDTH-1:0] pin_d, oe_d, pin_q, oe_q;
	always_comb begin
		pin_d = out_q;
		if (i_dir_out && active) begin
			oe_d = i_open_coll ? (~out_q & own) : own;
			if (i_open_coll) pin_d = '0;
		end else begin
			oe_d = '0;
		end
	end
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= '0;
			oe_q  <= '0;
		end else begin
			pin_q <= pin_d;
			oe_q  <= oe_d;
		end
	end

	assign o_pin           = pin_q;
	assign o_pin_oe        = oe_q;
	assign o_ack           = ack_q;
	assign o_done          = done_q;
	assign o_rd_data       = xfer_q;
	assign o_counter       = cnt_q;
	assign o_timestamp     = ts_q;
	assign o_output_strobe = stb_q;
	assign o_clk_blk       = clk_blk_q;

	//==========================================================================
	// Checks
	sequence s_timed_req;
		i_req && i_req_timed && active && st_q == iop_pkg::IOP_IDLE;
	endsequence
	// Input transfer parked on the strobe while the strobe is still low
	sequence s_stb_wait;
		st_q == iop_pkg::IOP_WAIT_STB && !stb_val_q;
	endsequence
	chk_oc_no_high: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		(oe_q != '0 && $past(i_open_coll) && $past(i_dir_out)) |-> pin_q == '0)
		else $error("open collector drove high");
	chk_link_quiet: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		$past(i_link_en) |-> oe_q == '0)
		else $error("pins driven while link enabled");
	chk_narrow_wins: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		(($past(i_narrow_own) & oe_q) == '0))
		else $error("wider port drove a taken pin");
	chk_counter_step: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		tick |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not advance");
	chk_counter_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		!tick |=> cnt_q == $past(cnt_q))
		else $error("counter moved without tick");
	chk_ack_one: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		(i_req && active && st_q == iop_pkg::IOP_IDLE) |=> o_ack)
		else $error("request not acked in one cycle");
	chk_timed_stamp: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		(st_q == iop_pkg::IOP_WAIT_TIME && done_d) |=> ts_q == tgt_q)
		else $error("timed transfer off target");
	chk_timed_wait: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		s_timed_req |=> st_q == iop_pkg::IOP_WAIT_TIME || !active)
		else $error("timed request not held");
	chk_reset_blk0: assert property (@(posedge i_ref_clk)
		$rose(rst_n) |-> clk_blk_q == 3'h0)
		else $error("port not on clock block 0");
	chk_dir_one: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		!$past(i_dir_out) |-> oe_q == '0)
		else $error("input port drove pins");
	chk_stb_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		s_stb_wait |=> !done_q)
		else $error("strobe wait ended without strobe");
	chk_stamp_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		!done_d |=> ts_q == $past(ts_q))
		else $error("timestamp moved without transfer");
endmodule : iop_port_clock_block
`default_nettype wire

// *** hdl/iop_pkg.sv ***
// Constants and types shared by the I/O port and clock block design
//==============================================================================
// Contract
// - Ports come in widths 1, 4, 8, 16 and 32 bits over physical pins.
// - All pins of one port share one direction, input or output.
// - Port drives pins high or low, or samples, optionally waiting on condition.
// - Each core port access completes within one processor cycle.
// - Open-collector mode: zero drives low, one leaves pin undriven.
// - Data moves through a serializer/deserializer plus a transfer register.
// - Each port has a 16-bit counter timing pin-to-transfer-register movement.
// - Counter readable anytime; a transfer can wait for a future count.
// - Each transfer captures the counter value as a readable timestamp.
// - An enabled link disables ports sharing its pins: no drive, no sample.
// - An enabled narrower port takes shared pins from an enabled wider port.
// - A partly overridden port keeps full width; lost pins ignored or undriven.
// - Six clock blocks; block 0 is the tile reference clock, others programmable.
// - A clock block may take a 1-bit port pin as its clock source.
// - A clock block fed from a 1-bit port may divide that clock.
// - Ports interpret an input strobe and can generate an output strobe.
// - After reset every port is attached to clock block 0.
//==============================================================================
`default_nettype none
package iop_pkg;
	localparam int          NUM_CLK_BLK    = 6;
	localparam int          CNT_W          = 16;
	localparam logic [2:0]  CLK_BLK_RST    = 3'h0;
	localparam logic [15:0] CNT_RST        = 16'h0000;
	localparam logic [7:0]  DIV_RST        = 8'h00;
	localparam int          SYNC_STAGES    = 3;
	// Reference clock block: 100 MHz taken from the 200 MHz system clock
	localparam int          SYS_CLK_MHZ    = 200;
	localparam int          REF_CLK_MHZ    = 100;
	localparam logic [7:0]  REF_DIV_CYC    = 8'(SYS_CLK_MHZ / REF_CLK_MHZ);

	// Clock source selection of clock blocks 1..5
	typedef enum logic [0:0] {
		IOP_SRC_REF,
		IOP_SRC_PIN
	} iop_src_t;

	// Port sequencer states
	typedef enum logic [1:0] {
		IOP_IDLE,
		IOP_WAIT_TIME,
		IOP_WAIT_COND,
		IOP_WAIT_STB
	} iop_state_t;
endpackage : iop_pkg
`default_nettype wire

// *** dv/iop_pin_model.sv ***
// External hardware model driving the port pins and an application clock
`timescale 1ns/1ps
`default_nettype none
module iop_pin_model #(
	parameter int WIDTH = 4
) (
	input  wire logic [WIDTH-1:0] i_pin_out,
	input  wire logic [WIDTH-1:0] i_pin_oe,
	input  wire logic [WIDTH-1:0] i_ext_val,
	input  wire logic [WIDTH-1:0] i_ext_drv,
	output logic      [WIDTH-1:0] o_level,
	output logic                  o_ext_clk
);
	//==========================================================================
	// Pin level: port drive first, then ours, else the pull-down
	always_comb begin
		for (int b = 0; b < WIDTH; b++) begin
			o_level[b] = i_pin_oe[b] ? i_pin_out[b] : (i_ext_drv[b] & i_ext_val[b]);
		end
	end

	//==========================================================================
	// Application clock stands still between bursts
	initial o_ext_clk = 1'b0;
	task automatic burst(input int n);
		repeat (n) begin
			#17 o_ext_clk = 1'b1;
			#17 o_ext_clk = 1'b0;
		end
	endtask : burst
endmodule : iop_pin_model
`default_nettype wire

// *** dv/io_port_clock_block_tb_top.sv ***
// Self-checking bench for one I/O port with its clock blocks
`timescale 1ns/1ps
`default_nettype none
module io_port_clock_block_tb_top;
	localparam int W = 4;
	localparam int S = 2;
	logic         clk, nrst, link_en, port_en, dir_out, open_coll, buffered, strobe_en;
	logic         blk_wr, req, timed, cond, ext_clk, ack, done, ostb, stb_in;
	logic [W-1:0] pin_lvl, narrow, cond_val, ext_val, ext_drv, o_pin, o_oe, v;
	logic [2:0]   blk_sel, o_blk;
	logic [4:0]   src_pin;
	logic [7:0]   div, rd, data, d;
	logic [15:0]  rtime, cnt, ts;
	int           n_fail, total_checks, n_ack, n_stb, e, t;
	bit           got;

	//==========================================================================
	// Clock and instances
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	iop_port_clock_block #(.WIDTH(W), .SHIFT(S)) i_iop_port_clock_block (
		.i_ref_clk(clk), .i_nrst(nrst), .i_pin(pin_lvl), .o_pin(o_pin), .o_pin_oe(o_oe),
		.i_link_en(link_en), .i_narrow_own(narrow), .i_port_en(port_en),
		.i_dir_out(dir_out), .i_open_coll(open_coll), .i_buffered(buffered),
		.i_strobe_en(strobe_en), .i_clk_blk_sel(blk_sel), .i_clk_blk_wr(blk_wr),
		.i_blk_src_pin(src_pin), .i_blk_div(div), .i_ext_clk_pin(ext_clk),
		.i_req(req), .i_req_timed(timed), .i_req_cond(cond), .i_req_time(rtime),
		.i_req_data(data), .i_cond_val(cond_val), .i_strobe_in(stb_in), .o_ack(ack),
		.o_done(done), .o_rd_data(rd), .o_counter(cnt), .o_timestamp(ts),
		.o_output_strobe(ostb), .o_clk_blk(o_blk));
	iop_pin_model #(.WIDTH(W)) i_iop_pin_model (
		.i_pin_out(o_pin), .i_pin_oe(o_oe), .i_ext_val(ext_val), .i_ext_drv(ext_drv),
		.o_level(pin_lvl), .o_ext_clk(ext_clk));

	//==========================================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Inputs move 1 ns after the edge so the design never races the bench
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic send(input logic t_on, input logic c_on, input logic [15:0] tv,
			input logic [7:0] dv);
		n_ack = 0;
		n_stb = 0;
		timed = t_on;
		cond = c_on;
		rtime = tv;
		data = dv;
		req = 1'b1;
		step(1);
		req = 1'b0;
	endtask : send
	// Bounded wait for the completion pulse, counting acks and strobes
	task automatic await(input int lim);
		got = 0;
		for (int i = 0; i < lim && !got; i++) begin
			if (ack === 1'b1) n_ack++;
			if (ostb === 1'b1) n_stb++;
			if (done === 1'b1) got = 1;
			else step(1);
		end
	endtask : await
	task automatic blk_write(input logic [2:0] s, input logic [7:0] dvs);
		blk_sel = s;
		div = dvs;
		blk_wr = 1'b1;
		step(1);
		blk_wr = 1'b0;
		step(2);
	endtask : blk_write

	//==========================================================================
	// Watchdog: the whole run needs well under 20000 cycles
	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end

	//==========================================================================
	// Main sequence
	initial begin
		{nrst, link_en, dir_out, open_coll, buffered, strobe_en, blk_wr, req} = '0;
		{timed, cond, narrow, cond_val, ext_val, ext_drv, blk_sel, div, data, rtime} = '0;
		port_en = 1'b1;
		stb_in = 1'b0;
		src_pin = 5'h01;
		n_fail = 0;
		total_checks = 0;
		void'($urandom(16073));
		step(3);
		nrst = 1'b1;
		step(3);
		check(o_blk, 3'h0);
		check(o_oe, 4'h0);
		e = cnt;
		step(20);
		check(cnt, 16'(e + 10));
		// Timed output with strobe, all pins driven
		dir_out = 1'b1;
		strobe_en = 1'b1;
		d = 8'($urandom);
		t = cnt + 8 + $urandom % 8;
		send(1'b1, 1'b0, 16'(t), d);
		await(100);
		check(got, 1);
		check(ts, 16'(t));
		repeat (2) begin
			step(1);
			if (ostb === 1'b1) n_stb++;
		end
		check(n_ack, 1);
		check(n_stb, 1);
		check(pin_lvl, d[W-1:0]);
		check(o_oe, 4'hf);
		// Open collector drives only the zeros
		strobe_en = 1'b0;
		open_coll = 1'b1;
		d = 8'($urandom);
		send(1'b0, 1'b0, 16'h0000, d);
		await(20);
		step(2);
		v = ~d[W-1:0];
		check(o_oe, v);
		check(o_pin & o_oe, 4'h0);
		open_coll = 1'b0;
		// Narrower port owns the two low pins
		narrow = 4'h3;
		send(1'b0, 1'b0, 16'h0000, 8'hff);
		await(20);
		step(2);
		check(o_oe, 4'hc);
		narrow = 4'h0;
		// Enabled link refuses the request and frees the pins
		link_en = 1'b1;
		send(1'b0, 1'b0, 16'h0000, 8'h5a);
		await(10);
		check(got, 0);
		check(n_ack, 0);
		check(o_oe, 4'h0);
		link_en = 1'b0;
		// Buffered input from steady pins
		dir_out = 1'b0;
		buffered = 1'b1;
		v = W'($urandom);
		ext_val = v;
		ext_drv = 4'hf;
		step(5);
		send(1'b0, 1'b0, 16'h0000, 8'h00);
		await(40);
		check(rd, {S{v}});
		// Conditional input waits for the pin pattern
		buffered = 1'b0;
		cond_val = v ^ 4'h5;
		step(1);
		send(1'b0, 1'b1, 16'h0000, 8'h00);
		await(30);
		check(got, 0);
		ext_val = cond_val;
		await(30);
		check(got, 1);
		check(rd, cond_val);
		// Input strobe from the far side gates the sample
		strobe_en = 1'b1;
		send(1'b0, 1'b0, 16'h0000, 8'h00);
		await(20);
		check(got, 0);
		stb_in = 1'b1;
		await(20);
		check(got, 1);
		check(rd, ext_val);
		stb_in = 1'b0;
		strobe_en = 1'b0;
		// Buffered timed output: later slice follows on the next port edge
		dir_out = 1'b1;
		buffered = 1'b1;
		d = 8'($urandom);
		t = cnt + 8 + $urandom % 8;
		send(1'b1, 1'b0, 16'(t), d);
		await(100);
		check(got, 1);
		check(ts, 16'(t + S - 1));
		step(2);
		check(pin_lvl, d[2*W-1:W]);
		buffered = 1'b0;
		// Clock block 1 from the external pin, then divided by two
		blk_write(3'h1, 8'h00);
		check(o_blk, 3'h1);
		e = cnt;
		i_iop_pin_model.burst(12);
		step(6);
		check(cnt, 16'(e + 12));
		blk_write(3'h1, 8'h01);
		e = cnt;
		i_iop_pin_model.burst(12);
		step(6);
		check(cnt, 16'(e + 6));
		// Second reset returns the port to block 0
		nrst = 1'b0;
		step(2);
		nrst = 1'b1;
		step(3);
		check(o_blk, 3'h0);
		wrap_up();
	end
endmodule : io_port_clock_block_tb_top
`default_nettype wire
